// file: hw/oic_consts.svh
/*
 Constants for the on-line I/O system control block: register map,
 command bits, button indices, character codes and timing.
 Assumes a 100 MHz system clock.
*/
// Notes on behaviour
// - All computer/device signals pass through controller
// - Pace computer from active devices' ready lines
// - One seven-bit character register for transfers
// - Selection characters and master reset alone produce selection strobe
// - Every input character checked for even parity
// - Up to sixty devices selectable and monitored
// - Go-ahead starts output, advance starts input
// - Parity error sets sticky flag, blocks flow
// - Parity reset clears flag, loads good code
// - Erroneous character still delivered unless stop
// - Parity inhibit frees start and ready outputs
// - Master reset loads unselect code and strobes
// - Duplication flag set/cleared; copies input out
// - Start read holds ready low, release starts
// - Stop read clears input-active flag
// - Start compute holds enable low, forces start
// - Single mode: one character, then compute
// - Otherwise codes below sixteen kept out
// - Single mode: one-shot start, begin stops input
// - One input device, many output devices
// - Each data character waits for slowest ready
// - Word input ends with the stop code
`ifndef OIC_CONSTS_SVH
`define OIC_CONSTS_SVH

`define OIC_REG_CTRL   4'h0
`define OIC_REG_CMD    4'h1
`define OIC_REG_STAT   4'h2
`define OIC_REG_CHAR   4'h3

`define OIC_CTRL_INHIB 0
`define OIC_CTRL_SNGL  1

`define OIC_CMD_PRST   0
`define OIC_CMD_MRST   1
`define OIC_CMD_DSEL   2
`define OIC_CMD_DRST   3
`define OIC_CMD_SRD    4
`define OIC_CMD_STRD   5

`define OIC_PB_N       9
`define OIC_PB_PRST    0
`define OIC_PB_MRST    1
`define OIC_PB_DSEL    2
`define OIC_PB_DRST    3
`define OIC_PB_SRD     4
`define OIC_PB_STRD    5
`define OIC_PB_SCMP    6
`define OIC_PB_INHIB   7
`define OIC_PB_SNGL    8

`define OIC_UNSEL_CODE 7'h7F
`define OIC_GOOD_CODE  7'h00
`define OIC_STOP_CODE  7'h0F
`define OIC_MIN_CODE   7'h10
`define OIC_SEL_BIT    6
`define OIC_UNSEL_IDX  6'h3F

`define OIC_CLK_NS     10
`define OIC_M_NS       1000
`define OIC_M_CYC      ((`OIC_M_NS + `OIC_CLK_NS - 1) / `OIC_CLK_NS)

`endif

// file: hw/oic_pkg.sv
/*
 Types for the on-line I/O system control block.
 Assumes oic_consts.svh for all numeric constants.
*/
package oic_pkg;
    typedef enum logic [2:0] {
        ST_IDLE, ST_SEL, ST_OGO, ST_OWAIT, ST_IADV, ST_IWAIT, ST_IDLV, ST_MRST
    } oic_state_t;

    // Lines toward the device bus
    typedef struct packed {
        logic [6:0] chr;
        logic       sel_stb;
        logic       unsel;
        logic       go;
        logic       adv;
    } oic_dev_o_t;

    // Lines toward the computer
    typedef struct packed {
        logic [6:0] chr;
        logic       chr_vld;
        logic       in_begin;
        logic       sync_rdy;
        logic       start_cmp;
        logic       in_en_cmp;
    } oic_cpu_o_t;
endpackage : oic_pkg

// file: hw/oic_ctrl.sv
/*
 On-line I/O system control: sits between the computer and up to sixty
 character devices on shared bus lines, with panel buttons and a small
 register port. Assumes one 100 MHz clock and synchronous inputs.
*/
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "oic_consts.svh"

module oic_ctrl import oic_pkg::*; #(
    parameter int DEV_N = 60,
    parameter int IN_N  = 30
) (
    input  wire logic                  clk_sys_i,
    input  wire logic                  rst_n_i,
    input  wire logic [3:0]            reg_addr_i,
    input  wire logic [7:0]            reg_wdata_i,
    input  wire logic                  reg_wr_i,
    input  wire logic                  reg_rd_i,
    output      logic [7:0]            reg_rdata_o,
    input  wire logic [`OIC_PB_N-1:0]  panel_i,
    input  wire logic [6:0]            cpu_chr_i,
    input  wire logic                  cpu_chr_vld_i,
    input  wire logic                  cpu_in_req_i,
    output      oic_cpu_o_t            cpu_o,
    input  wire logic [6:0]            dev_chr_i,
    input  wire logic                  dev_chr_vld_i,
    input  wire logic [DEV_N-1:0]      dev_rdy_i,
    output      oic_dev_o_t            dev_o,
    output      logic [DEV_N-1:0]      dev_sel_o,
    output      logic                  par_err_o
);
    oic_state_t        st_reg;
    oic_state_t        st_next;
    logic [6:0]        chr_reg;
    logic [6:0]        chr_next;
    logic              err_reg;
    logic              act_reg;
    logic              dup_reg;
    logic [1:0]        ctrl_reg;
    logic [DEV_N-1:0]  sel_reg;
    logic [DEV_N-1:0]  sel_upd;
    logic [15:0]       m_cnt_reg;
    logic [`OIC_PB_N-1:0] s1_reg;
    logic [`OIC_PB_N-1:0] s2_reg;
    logic [`OIC_PB_N-1:0] s3_reg;

    // Panel buttons: two-flop synchroniser, third flop for edges
    genvar gi;
    generate
        for (gi = 0; gi < `OIC_PB_N; gi++) begin : g_sync
            always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    s1_reg[gi] <= 1'b0;
                    s2_reg[gi] <= 1'b0;
                    s3_reg[gi] <= 1'b0;
                end else begin
                    s1_reg[gi] <= panel_i[gi];
                    s2_reg[gi] <= s1_reg[gi];
                    s3_reg[gi] <= s2_reg[gi];
                end
            end
        end
    endgenerate

    wire [`OIC_PB_N-1:0] pb_rise = s2_reg & ~s3_reg;
    wire [`OIC_PB_N-1:0] pb_fall = ~s2_reg & s3_reg;

    // Register port decode
    wire       wr_ctrl = reg_wr_i && (reg_addr_i == `OIC_REG_CTRL);
    wire       wr_cmd  = reg_wr_i && (reg_addr_i == `OIC_REG_CMD);
    wire [7:0] cmd     = wr_cmd ? reg_wdata_i : 8'h00;

    // Panel and program commands merge into one pulse each
    wire prst    = pb_rise[`OIC_PB_PRST] | cmd[`OIC_CMD_PRST];
    wire mrst    = pb_rise[`OIC_PB_MRST] | cmd[`OIC_CMD_MRST];
    wire dsel    = pb_rise[`OIC_PB_DSEL] | cmd[`OIC_CMD_DSEL];
    wire drst    = pb_rise[`OIC_PB_DRST] | cmd[`OIC_CMD_DRST];
    wire srd_go  = pb_fall[`OIC_PB_SRD] | cmd[`OIC_CMD_SRD];
    wire stop_rd = pb_rise[`OIC_PB_STRD] | cmd[`OIC_CMD_STRD];
    wire srd_hold = s2_reg[`OIC_PB_SRD];
    wire sc_hold  = s2_reg[`OIC_PB_SCMP];
    wire inhib    = s2_reg[`OIC_PB_INHIB] | ctrl_reg[`OIC_CTRL_INHIB];
    wire single   = s2_reg[`OIC_PB_SNGL] | ctrl_reg[`OIC_CTRL_SNGL];

    // Error blocks flow unless inhibited
    wire blk = err_reg & ~inhib;

    // Character from the computer: bit 6 marks a selection pattern
    wire       is_sel  = cpu_chr_i[`OIC_SEL_BIT];
    wire [5:0] sel_idx = cpu_chr_i[5:0];
    wire       unsel   = sel_idx == `OIC_UNSEL_IDX;
    wire       idx_in  = 32'(sel_idx) < IN_N;
    wire       take_o  = (st_reg == ST_IDLE) && cpu_chr_vld_i && !blk && !mrst;

    // New selection mask; an input pick drops other inputs
    generate
        for (gi = 0; gi < DEV_N; gi++) begin : g_sel
            if (gi < IN_N) begin : g_in
                assign sel_upd[gi] = unsel ? 1'b0 :
                                     (32'(sel_idx) == gi) ? 1'b1 :
                                     idx_in ? 1'b0 : sel_reg[gi];
            end else begin : g_out
                assign sel_upd[gi] = unsel ? 1'b0 :
                                     (32'(sel_idx) == gi) ? 1'b1 : sel_reg[gi];
            end
        end
    endgenerate

    // Slowest selected device sets the pace
    wire rdy_all = &(~sel_reg | dev_rdy_i);
    wire in_sel  = |sel_reg[IN_N-1:0];

    // Input character delivery decisions
    wire in_take  = (st_reg == ST_IWAIT) && dev_chr_vld_i;
    wire bad_par  = ^dev_chr_i;
    wire is_stop  = chr_reg == `OIC_STOP_CODE;
    wire dlv      = st_reg == ST_IDLV;
    wire pass     = single || (chr_reg >= `OIC_MIN_CODE);
    wire chr_out  = dlv && pass && !(is_stop && !single);
    wire stop_hit = dlv && !single && is_stop && !blk;
    wire one_shot = dlv && single;

    // Sequencer
    always_comb begin
        st_next = st_reg;
        unique case (st_reg)
            ST_IDLE: begin
                if (take_o)
                    st_next = is_sel ? ST_SEL : ST_OGO;
                else if (act_reg && cpu_in_req_i && !blk && !srd_hold && in_sel)
                    st_next = ST_IADV;
            end
            ST_SEL:   st_next = ST_IDLE;
            ST_OGO:   st_next = ST_OWAIT;
            ST_OWAIT: if (rdy_all) st_next = ST_IDLE;
            ST_IADV:  st_next = ST_IWAIT;
            ST_IWAIT: begin
                if (dev_chr_vld_i)
                    st_next = ST_IDLV;
                else if (stop_rd)
                    st_next = ST_IDLE;
            end
            ST_IDLV:  st_next = dup_reg ? ST_OGO : ST_OWAIT;
            ST_MRST:  st_next = ST_IDLE;
        endcase
        if (mrst)
            st_next = ST_MRST;
    end

    // Single character register, shared by both directions
    always_comb begin
        chr_next = chr_reg;
        if (take_o)
            chr_next = cpu_chr_i;
        else if (in_take)
            chr_next = dev_chr_i;
        if (prst)
            chr_next = `OIC_GOOD_CODE;
        if (mrst)
            chr_next = `OIC_UNSEL_CODE;
    end

    // Main state and character
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg  <= ST_IDLE;
            chr_reg <= `OIC_UNSEL_CODE;
        end else begin
            st_reg  <= st_next;
            chr_reg <= chr_next;
        end
    end

    // Flags; a set in the same cycle as its clear wins
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            err_reg <= 1'b0;
            act_reg <= 1'b0;
            dup_reg <= 1'b0;
        end else begin
            if (in_take && bad_par)
                err_reg <= 1'b1;
            else if (prst)
                err_reg <= 1'b0;
            if (srd_go)
                act_reg <= 1'b1;
            else if (stop_rd || one_shot || mrst)
                act_reg <= 1'b0;
            if (dsel)
                dup_reg <= 1'b1;
            else if (drst)
                dup_reg <= 1'b0;
        end
    end

    // Selection mirror and one-shot timer for single mode
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sel_reg   <= '0;
            m_cnt_reg <= 16'h0000;
        end else begin
            if (mrst)
                sel_reg <= '0;
            else if (take_o && is_sel)
                sel_reg <= sel_upd;
            if (one_shot)
                m_cnt_reg <= 16'(`OIC_M_CYC);
            else if (m_cnt_reg != 16'h0000)
                m_cnt_reg <= m_cnt_reg - 16'h0001;
        end
    end

    // Registered outputs toward both sides; nothing bypasses the block
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dev_o     <= '0;
            cpu_o     <= '0;
            dev_sel_o <= '0;
            par_err_o <= 1'b0;
        end else begin
            dev_o.chr       <= chr_next;
            dev_o.sel_stb   <= (st_next == ST_SEL) || (st_next == ST_MRST);
            dev_o.unsel     <= chr_next == `OIC_UNSEL_CODE;
            dev_o.go        <= st_next == ST_OGO;
            dev_o.adv       <= st_next == ST_IADV;
            cpu_o.chr       <= chr_reg;
            cpu_o.chr_vld   <= chr_out;
            cpu_o.in_begin  <= chr_out;
            cpu_o.sync_rdy  <= (st_next == ST_IDLE) && !srd_hold && !blk;
            cpu_o.start_cmp <= sc_hold || stop_hit || one_shot ||
                               (m_cnt_reg > 16'h0001);
            cpu_o.in_en_cmp <= act_reg && !sc_hold && !blk;
            dev_sel_o       <= sel_reg;
            par_err_o       <= err_reg;
        end
    end

    // Register read: one cycle after the strobe, zero elsewhere
    wire [7:0] stat_w = {4'h0, in_sel, dup_reg, act_reg, err_reg};
    wire [7:0] rd_mux = (reg_addr_i == `OIC_REG_CTRL) ? {6'h00, ctrl_reg} :
                        (reg_addr_i == `OIC_REG_STAT) ? stat_w :
                        (reg_addr_i == `OIC_REG_CHAR) ? {1'b0, chr_reg} : 8'h00;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_reg    <= 2'h0;
            reg_rdata_o <= 8'h00;
        end else begin
            if (wr_ctrl)
                ctrl_reg <= reg_wdata_i[1:0];
            reg_rdata_o <= reg_rd_i ? rd_mux : 8'h00;
        end
    end

    // Checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_out_take;
        take_o && !is_sel;
    endsequence
    sequence s_go_pulse;
        dev_o.go ##1 !dev_o.go;
    endsequence

    AST_OUT_GO: assert property (s_out_take |=> s_go_pulse)
        else $error("output char did not give one go-ahead");
    AST_SEL_STB: assert property (take_o && is_sel |=> dev_o.sel_stb && !dev_o.go)
        else $error("selection char did not strobe");
    AST_NO_STB: assert property (take_o && !is_sel |=> !dev_o.sel_stb)
        else $error("data char produced a strobe");
    AST_PAR_ERR: assert property (in_take && bad_par |=> err_reg [*2])
        else $error("parity error flag not held");
    AST_PAR_RST: assert property (prst && !mrst && !(in_take && bad_par)
                                  |=> !err_reg && chr_reg == `OIC_GOOD_CODE)
        else $error("parity reset failed");
    AST_MRST: assert property (mrst |=> dev_o.sel_stb && dev_o.unsel)
        else $error("master reset did not strobe unselect");
    AST_BLOCK: assert property (blk && st_reg == ST_IDLE |=> !dev_o.go && !dev_o.adv)
        else $error("flow not blocked on error");
    AST_SRD_HOLD: assert property (srd_hold |=> !cpu_o.sync_rdy)
        else $error("ready not held low during start read");
    AST_STOP: assert property (stop_rd && !srd_go |=> !act_reg)
        else $error("stop read did not clear input");
    AST_SCMP: assert property (sc_hold |=> cpu_o.start_cmp && !cpu_o.in_en_cmp)
        else $error("start compute hold not reflected");
    AST_LOW_CODE: assert property (dlv && !single && chr_reg < `OIC_MIN_CODE
                                   |=> !cpu_o.chr_vld)
        else $error("low code entered computer");
    AST_SINGLE: assert property (one_shot && !srd_go |=> !act_reg && cpu_o.chr_vld)
        else $error("single mode did not stop input");
    AST_ONE_IN: assert property ($countones(sel_reg[IN_N-1:0]) <= 1)
        else $error("more than one input device selected");
    AST_WAIT: assert property (st_reg == ST_OWAIT && !rdy_all && !mrst
                               |=> st_reg == ST_OWAIT)
        else $error("left wait before all ready");
endmodule : oic_ctrl

// file: testbench/oic_dev_model.sv
/*
 Behavioural far side of the device bus: selection flops, ready lines,
 one input device that answers an advance with a character.
 Assumes the controller's registered dev_o struct and one clock.
*/
`timescale 1ns/1ps

module oic_dev_model import oic_pkg::*; #(
    parameter int DEV_N = 60,
    parameter int IN_N  = 30
) (
    input  wire logic             clk_sys_i,
    input  wire logic             rst_n_i,
    input  wire oic_dev_o_t       dev_i,
    input  wire logic [6:0]       in_chr_i,
    input  wire logic [7:0]       lag_i,
    output      logic [6:0]       dev_chr_o,
    output      logic             dev_chr_vld_o,
    output      logic [DEV_N-1:0] dev_rdy_o
);
    logic [DEV_N-1:0] sel_reg;
    logic [7:0]       out_cnt;
    logic [7:0]       in_cnt;

    // Selection flops, busy counters and the input character line
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sel_reg       <= '0;
            out_cnt       <= 8'h00;
            in_cnt        <= 8'h00;
            dev_chr_vld_o <= 1'b0;
            dev_chr_o     <= 7'h00;
        end else begin
            dev_chr_vld_o <= 1'b0;
            dev_chr_o     <= ~dev_chr_o; // Released bus inverts each cycle, so the last character returns every other cycle
            if (dev_i.sel_stb && dev_i.unsel) begin
                sel_reg <= '0;
            end else if (dev_i.sel_stb && dev_i.chr[6]) begin
                sel_reg[dev_i.chr[5:0]] <= 1'b1;
            end
            if (dev_i.go) begin
                out_cnt <= lag_i;
            end else if (out_cnt != 8'h00) begin
                out_cnt <= out_cnt - 8'h01;
            end
            if (dev_i.adv && |sel_reg[IN_N-1:0]) begin
                in_cnt <= lag_i + 8'h01;
            end else if (in_cnt != 8'h00) begin
                in_cnt <= in_cnt - 8'h01;
            end
            if (in_cnt == 8'h01) begin
                dev_chr_vld_o <= 1'b1;
                dev_chr_o     <= in_chr_i;
            end
        end
    end

    // Ready drops in the very cycle of go or advance, as slow hardware would
    always_comb begin
        for (int i = 0; i < DEV_N; i++) begin
            dev_rdy_o[i] = (i < IN_N) ? (in_cnt == 8'h00 && !dev_i.adv)
                                      : (out_cnt == 8'h00 && !dev_i.go);
        end
    end
endmodule : oic_dev_model

// file: testbench/online_io_system_control_bench.sv
/*
 Self-checking bench: register port, panel and computer side driven here,
 device side answered by oic_dev_model. Assumes a 100 MHz clock.
*/
`timescale 1ns/1ps
`include "oic_consts.svh"

module online_io_system_control_bench import oic_pkg::*;;
    logic                 clk_sys_i;
    logic                 rst_n_i;
    logic [3:0]           reg_addr;
    logic [7:0]           reg_wdata;
    logic                 reg_wr;
    logic                 reg_rd;
    logic [7:0]           reg_rdata;
    logic [`OIC_PB_N-1:0] panel;
    logic [6:0]           cpu_chr;
    logic                 cpu_chr_vld;
    logic                 cpu_in_req;
    oic_cpu_o_t           cpu_o;
    logic [6:0]           dev_chr;
    logic                 dev_chr_vld;
    logic [59:0]          dev_rdy;
    oic_dev_o_t           dev_o;
    logic [59:0]          dev_sel;
    logic                 par_err;
    logic [6:0]           in_chr;
    logic [7:0]           lag;
    logic [7:0]           rv;
    logic [6:0]           r_chr;
    logic                 r_adv, r_vld, r_go, r_stb, r_sc;
    int                   r_n, n_fail, comparisons;

    oic_ctrl #(.DEV_N(60), .IN_N(30)) dut (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_rdata_o(reg_rdata), .panel_i(panel), .cpu_chr_i(cpu_chr),
        .cpu_chr_vld_i(cpu_chr_vld), .cpu_in_req_i(cpu_in_req), .cpu_o(cpu_o),
        .dev_chr_i(dev_chr), .dev_chr_vld_i(dev_chr_vld), .dev_rdy_i(dev_rdy),
        .dev_o(dev_o), .dev_sel_o(dev_sel), .par_err_o(par_err));

    oic_dev_model #(.DEV_N(60), .IN_N(30)) far (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .dev_i(dev_o), .in_chr_i(in_chr),
        .lag_i(lag), .dev_chr_o(dev_chr), .dev_chr_vld_o(dev_chr_vld),
        .dev_rdy_o(dev_rdy));

    // Free-running system clock
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask : cyc

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a);
        @(posedge clk_sys_i);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd   <= 1'b0;
        #1 rv = reg_rdata;
    endtask : rd

    // One character offered by the computer, then wait for ready
    task automatic send(input logic [6:0] c);
        @(posedge clk_sys_i);
        cpu_chr     <= c;
        cpu_chr_vld <= 1'b1;
        @(posedge clk_sys_i);
        cpu_chr_vld <= 1'b0;
        #1;
        r_go  = dev_o.go;
        r_stb = dev_o.sel_stb;
        r_chr = dev_o.chr;
        r_n   = 0;
        while (cpu_o.sync_rdy !== 1'b1 && r_n < 500) begin
            @(posedge clk_sys_i);
            #1 r_n++;
        end
    endtask : send

    // One input request; what reaches the computer is recorded
    task automatic inp(input logic [6:0] c);
        r_adv = 1'b0;
        r_vld = 1'b0;
        r_go  = 1'b0;
        r_sc  = 1'b0;
        r_chr = 7'h00;
        @(posedge clk_sys_i);
        in_chr     <= c;
        cpu_in_req <= 1'b1;
        for (int i = 0; i < 80; i++) begin
            @(posedge clk_sys_i);
            if (r_adv) cpu_in_req <= 1'b0; // Held until the advance is seen
            #1;
            if (dev_o.adv === 1'b1) r_adv = 1'b1;
            if (dev_o.go === 1'b1) r_go = 1'b1;
            if (cpu_o.start_cmp === 1'b1) r_sc = 1'b1;
            if (cpu_o.chr_vld === 1'b1 && cpu_o.in_begin === 1'b1) begin
                r_vld = 1'b1;
                r_chr = cpu_o.chr;
            end
        end
        cpu_in_req <= 1'b0;
    endtask : inp

    // Watchdog: the whole sequence needs well under 5000 cycles
    initial begin
        cyc(20000);
        n_fail++;
        test_done();
    end

    initial begin
        rst_n_i = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        panel = '0;
        cpu_chr = 7'h00;
        cpu_chr_vld = 1'b0;
        cpu_in_req = 1'b0;
        in_chr = 7'h00;
        lag = 8'h28;
        cyc(16);
        rst_n_i <= 1'b1;
        cyc(2);
        #1 chk("chr", {1'b0, dev_o.chr}, 8'h7F);
        chk("unsel", 8'(dev_o.unsel), 8'h01);
        chk("rdy", 8'(cpu_o.sync_rdy), 8'h01);
        chk("err", 8'(par_err), 8'h00);
        rd(`OIC_REG_CTRL);
        chk("ctrl", rv, 8'h00);
        rd(4'h9);
        chk("unmapped", rv, 8'h00);
        $display("test reset done");
        send(7'h63);
        chk("stb", 8'(r_stb), 8'h01);
        chk("go", 8'(r_go), 8'h00);
        send(7'h68);
        chk("sel", {6'h00, dev_sel[40], dev_sel[35]}, 8'h03);
        send(7'h25);
        chk("go", 8'(r_go), 8'h01);
        chk("stb", 8'(r_stb), 8'h00);
        chk("chr", {1'b0, r_chr}, 8'h25);
        chk("slow", 8'(r_n >= 40), 8'h01);
        $display("test output done");
        lag <= 8'h03;
        send(7'h43);
        chk("insel", 8'(dev_sel[3]), 8'h01);
        @(posedge clk_sys_i) panel[`OIC_PB_SRD] <= 1'b1;
        cyc(6);
        #1 chk("rdy", 8'(cpu_o.sync_rdy), 8'h00);
        @(posedge clk_sys_i) panel[`OIC_PB_SRD] <= 1'b0;
        cyc(6);
        rd(`OIC_REG_STAT);
        chk("act", 8'(rv[1]), 8'h01);
        chk("en", 8'(cpu_o.in_en_cmp), 8'h01);
        inp(7'h33);
        chk("in", {r_adv, r_vld, r_chr[5:0]}, 8'hF3);
        inp(7'h05);
        chk("low", 8'(r_vld), 8'h00);
        inp(7'h0F);
        chk("stop", {r_vld, r_sc}, 8'h01);
        $display("test input done");
        wr(`OIC_REG_CMD, 8'h10);
        inp(7'h31);
        chk("bad", {r_vld, r_chr}, 8'hB1);
        chk("err", 8'(par_err), 8'h01);
        inp(7'h33);
        chk("blk", 8'(r_adv), 8'h00);
        wr(`OIC_REG_CTRL, 8'h01);
        inp(7'h33);
        chk("inh", {r_adv, r_vld}, 8'h03);
        wr(`OIC_REG_CTRL, 8'h00);
        wr(`OIC_REG_CMD, 8'h01);
        rd(`OIC_REG_CHAR);
        chk("good", rv, 8'h00);
        chk("err", 8'(par_err), 8'h00);
        $display("test parity done");
        @(posedge clk_sys_i) panel[`OIC_PB_DSEL] <= 1'b1;
        cyc(3);
        panel[`OIC_PB_DSEL] <= 1'b0;
        cyc(6);
        rd(`OIC_REG_STAT);
        chk("dup", 8'(rv[2]), 8'h01);
        inp(7'h44);
        chk("copy", {r_vld, r_go}, 8'h03);
        wr(`OIC_REG_CMD, 8'h08);
        rd(`OIC_REG_STAT);
        chk("dup", 8'(rv[2]), 8'h00);
        $display("test duplication done");
        wr(`OIC_REG_CTRL, 8'h02);
        inp(7'h05);
        chk("one", {r_vld, r_chr}, 8'h85);
        chk("cmp", 8'(r_sc), 8'h01);
        rd(`OIC_REG_STAT);
        chk("act", 8'(rv[1]), 8'h00);
        wr(`OIC_REG_CTRL, 8'h00);
        cyc(120);
        @(posedge clk_sys_i) panel[`OIC_PB_SCMP] <= 1'b1;
        cyc(5);
        #1 chk("scmp", {cpu_o.in_en_cmp, cpu_o.start_cmp}, 8'h01);
        @(posedge clk_sys_i) panel[`OIC_PB_SCMP] <= 1'b0;
        $display("test modes done");
        wr(`OIC_REG_CMD, 8'h02);
        r_stb = 1'b0;
        for (int i = 0; i < 3; i++) begin
            #1 if (dev_o.sel_stb === 1'b1) r_stb = 1'b1;
            @(posedge clk_sys_i);
        end
        #1 chk("mrst", {r_stb, dev_o.chr}, 8'hFF);
        chk("clr", 8'(|dev_sel), 8'h00);
        $display("test master reset done");
        test_done();
    end
endmodule : online_io_system_control_bench
